/* logic/ifc_cal_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ifc_cal_if;
  import ifc_pkg::*;
  logic                  start;
  logic                  fine_en;
  logic [DWELL_W-1:0]    dwell;
  logic [SEQ_DIV_W-1:0]  seq_div;
  logic [IF_DIV_W-1:0]   if_div;
  logic                  busy;
  logic                  fine_phase;
  logic                  tone_upper;
  logic                  done;
  logic                  fine_done;
  modport ctrl (output start, fine_en, dwell, seq_div, if_div,
                input busy, fine_phase, tone_upper, done, fine_done);
  modport seq  (input start, fine_en, dwell, seq_div, if_div,
                output busy, fine_phase, tone_upper, done, fine_done);
endinterface : ifc_cal_if
`default_nettype wire

/* logic/ifc_cal_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module ifc_cal_seq
  import ifc_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // control side
  ifc_cal_if.seq    cal
);
  typedef enum logic [1:0] {S_IDLE, S_COARSE, S_FINE} ifc_seq_state_t;

  ifc_seq_state_t       state;
  logic [SEQ_DIV_W-1:0] seq_cnt;
  logic [IF_DIV_W-1:0]  if_cnt;
  logic                 seq_tick;
  logic                 if_tick;
  logic [7:0]           coarse_cnt;
  logic [DWELL_W-1:0]   dwell_cnt;
  logic [3:0]           tone_cnt;
  logic                 fine_armed;

  function automatic logic hit(input logic [SEQ_DIV_W-1:0] cnt,
                               input logic [SEQ_DIV_W-1:0] div);
    // a divide of zero behaves as one
    hit = (div == '0) || (cnt >= div - 16'h0001);
  endfunction : hit

  // sequencer clock enable from the system clock
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || hit(seq_cnt, cal.seq_div)) begin
      seq_cnt <= '0;
    end else begin
      seq_cnt <= seq_cnt + 16'h0001;
    end
  end
  assign seq_tick = hit(seq_cnt, cal.seq_div);

  // if filter reference tick
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || hit({7'h00, if_cnt}, {7'h00, cal.if_div})) begin
      if_cnt <= '0;
    end else begin
      if_cnt <= if_cnt + 9'h001;
    end
  end
  assign if_tick = hit({7'h00, if_cnt}, {7'h00, cal.if_div});

  always_ff @(posedge i_clock) begin
    cal.done      <= 1'b0;
    cal.fine_done <= 1'b0;
    if (i_sys_rst) begin
      state          <= S_IDLE;
      coarse_cnt     <= '0;
      dwell_cnt      <= '0;
      tone_cnt       <= '0;
      fine_armed     <= 1'b0;
      cal.tone_upper <= 1'b0;
    end else if (cal.start) begin
      // a new trigger restarts the whole sequence
      state          <= S_COARSE;
      fine_armed     <= cal.fine_en;
      coarse_cnt     <= '0;
      dwell_cnt      <= '0;
      tone_cnt       <= '0;
      cal.tone_upper <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          coarse_cnt <= '0;
        end
        S_COARSE: begin
          if (if_tick) begin
            if (coarse_cnt == 8'(COARSE_TICKS - 1)) begin
              if (fine_armed) begin
                state <= S_FINE;
              end else begin
                state    <= S_IDLE;
                cal.done <= 1'b1;
              end
            end else begin
              coarse_cnt <= coarse_cnt + 8'h01;
            end
          end
        end
        S_FINE: begin
          if (seq_tick) begin
            // each tone lasts dwell sequencer periods
            if (dwell_cnt + 11'h001 >= cal.dwell) begin
              dwell_cnt      <= '0;
              cal.tone_upper <= ~cal.tone_upper;
              if (tone_cnt == 4'(FINE_DWELLS - 1)) begin
                state         <= S_IDLE;
                cal.done      <= 1'b1;
                cal.fine_done <= 1'b1;
                tone_cnt      <= '0;
              end else begin
                tone_cnt <= tone_cnt + 4'h1;
              end
            end else begin
              dwell_cnt <= dwell_cnt + 11'h001;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  assign cal.busy       = (state != S_IDLE);
  assign cal.fine_phase = (state == S_FINE);
endmodule : ifc_cal_seq
`default_nettype wire

/* logic/ifc_filter_cal_top.sv */
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ifc_filter_cal_top
  import ifc_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_sys_rst,
  // apb slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  output logic [31:0]               o_prdata,
  // receiver state and measured codes
  input  wire logic                 i_rx_mode,
  input  wire logic [RB_CODE_W-1:0] i_rssi_code,
  input  wire logic [RB_CODE_W-1:0] i_batt_code,
  input  wire logic [RB_CODE_W-1:0] i_temp_code,
  input  wire logic [RB_CODE_W-1:0] i_ext_code,
  input  wire logic [RB_CODE_W-1:0] i_fcal_code,
  // filter controls
  output logic [IF_TRIM_W-1:0]      o_filter_trim,
  output logic                      o_cal_active,
  output logic                      o_cal_fine,
  output logic                      o_cal_tone_upper,
  output logic                      o_cal_done,
  output logic                      o_adc_power_on,
  // image rejection controls
  output logic [IR_PH_W-1:0]        o_ir_phase_correction,
  output logic                      o_ir_phase_dir,
  output logic [IR_GM_W-1:0]        o_ir_gain_correction_size,
  output logic                      o_ir_gain_channel_select,
  output logic                      o_ir_gain_dir,
  output logic [1:0]                o_ir_test_source_strength,
  output logic                      o_ir_test_source_halve,
  // demodulator controls
  output logic [DISC_W-1:0]         o_discriminator_width_word,
  output logic [POST_W-1:0]         o_post_detector_filter_word,
  output logic                      o_correlator_combine_select
);
  ifc_cal_if cal ();

  logic [31:0]          demod_setup;
  logic [31:0]          if_filter_setup;
  logic [31:0]          fine_setup;
  logic [2:0]           rb_sel;
  logic [31:0]          pwr_ctrl;
  logic [SEQ_DIV_W-1:0] seq_div;
  logic                 start_pulse;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic [RB_CODE_W-1:0] rb_code;
  logic                 rb_valid;
  logic [31:0]          next_rdata;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFS_RB_DATA);
  endfunction : mapped

  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction : wr_hit

  // zero-wait slave: one access cycle, pready from a flop
  assign addr_ok = mapped(i_paddr);
  assign wr_en   = i_psel && i_penable && o_pready && i_pwrite && addr_ok;
  assign rd_en   = i_psel && !i_penable && !i_pwrite;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !addr_ok;
    end
  end

  // demodulator setup word
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      demod_setup <= 32'h0000_0000;
    end else if (wr_hit(wr_en, i_paddr, OFS_DEMOD)) begin
      demod_setup <= i_pwdata;
    end
  end

  // filter setup word; a write with the trigger bit starts calibration
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      if_filter_setup <= IF_SET_RST;
      start_pulse     <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      if (wr_hit(wr_en, i_paddr, OFS_IF_SET)) begin
        // address nibble is fixed, so readback always shows it
        if_filter_setup <= {i_pwdata[31:4], IF_SET_ADDR};
        start_pulse     <= i_pwdata[IF_COARSE_BIT];
      end
    end
  end

  // fine setup: enable only arms, never starts
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      fine_setup <= 32'h0000_0000;
    end else if (wr_hit(wr_en, i_paddr, OFS_FINE)) begin
      fine_setup <= i_pwdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rb_sel <= 3'h0;
    end else if (wr_hit(wr_en, i_paddr, OFS_RB_SEL)) begin
      rb_sel <= i_pwdata[RB_SEL_LSB +: 3];
    end
  end

  // converter power bit resets low so it stays off in transmit
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pwr_ctrl <= 32'h0000_0000;
    end else if (wr_hit(wr_en, i_paddr, OFS_PWR)) begin
      pwr_ctrl <= {23'h000000, i_pwdata[PWR_ADC_BIT], 8'h00};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      seq_div <= SEQ_DIV_RST;
    end else if (wr_hit(wr_en, i_paddr, OFS_SEQ_DIV)) begin
      seq_div <= i_pwdata[SEQ_DIV_W-1:0];
    end
  end

  // sequencer hookup
  assign cal.start   = start_pulse;
  assign cal.fine_en = fine_setup[FINE_EN_BIT];
  assign cal.dwell   = fine_setup[DWELL_LSB +: DWELL_W];
  assign cal.seq_div = seq_div;
  assign cal.if_div  = if_filter_setup[IF_DIV_LSB +: IF_DIV_W];

  ifc_cal_seq u_seq (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .cal       (cal.seq)
  );

  // done flag: a finish wins over the clear from a new trigger
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cal_done <= 1'b0;
    end else if (cal.done) begin
      o_cal_done <= 1'b1;
    end else if (start_pulse) begin
      o_cal_done <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cal_active     <= 1'b0;
      o_cal_fine       <= 1'b0;
      o_cal_tone_upper <= 1'b0;
    end else begin
      o_cal_active     <= cal.busy;
      o_cal_fine       <= cal.fine_phase;
      o_cal_tone_upper <= cal.tone_upper;
    end
  end

  // trim follows the last write; a fine pass then overrides it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_filter_trim <= '0;
    end else if (wr_hit(wr_en, i_paddr, OFS_IF_SET)) begin
      o_filter_trim <= i_pwdata[IF_TRIM_LSB +: IF_TRIM_W];
    end else if (cal.fine_done) begin
      // readback minus 128, low bits hold the signed result
      o_filter_trim <= 6'(i_fcal_code - 8'h80);
    end
  end

  // image rejection and demodulator fields straight from registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_ir_phase_correction     <= '0;
      o_ir_phase_dir            <= 1'b0;
      o_ir_gain_correction_size <= '0;
      o_ir_gain_channel_select  <= 1'b0;
      o_ir_gain_dir             <= 1'b0;
      o_ir_test_source_strength <= 2'h0;
      o_ir_test_source_halve    <= 1'b0;
    end else begin
      o_ir_phase_correction     <=
        if_filter_setup[IR_PH_LSB +: IR_PH_W];
      o_ir_phase_dir            <= if_filter_setup[IR_PH_DIR_BIT];
      o_ir_gain_correction_size <=
        if_filter_setup[IR_GM_LSB +: IR_GM_W];
      o_ir_gain_channel_select  <= if_filter_setup[IR_GQ_BIT];
      o_ir_gain_dir             <= if_filter_setup[IR_GDIR_BIT];
      o_ir_test_source_strength <=
        fine_setup[SRC_STR_LSB +: 2];
      o_ir_test_source_halve    <= fine_setup[SRC_HALVE_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_discriminator_width_word  <= '0;
      o_post_detector_filter_word <= '0;
      o_correlator_combine_select <= 1'b0;
    end else begin
      o_discriminator_width_word  <= demod_setup[DISC_LSB +: DISC_W];
      o_post_detector_filter_word <= demod_setup[POST_LSB +: POST_W];
      o_correlator_combine_select <= demod_setup[DOT_BIT];
    end
  end

  // converter runs in receive, or in transmit when host powers it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_adc_power_on <= 1'b0;
    end else begin
      o_adc_power_on <= i_rx_mode || pwr_ctrl[PWR_ADC_BIT];
    end
  end

  // readback source and validity
  always_comb begin
    rb_code  = i_fcal_code;
    rb_valid = 1'b1;
    case (rb_sel)
      RB_RSSI: begin
        rb_code  = i_rssi_code;
        rb_valid = i_rx_mode;
      end
      RB_BATT: begin
        rb_code  = i_batt_code;
        rb_valid = !i_rx_mode && o_adc_power_on;
      end
      RB_TEMP: begin
        rb_code  = i_temp_code;
        rb_valid = !i_rx_mode && o_adc_power_on;
      end
      RB_EXT: begin
        rb_code  = i_ext_code;
        rb_valid = !i_rx_mode && o_adc_power_on;
      end
      default: begin
        rb_code  = i_fcal_code;
        rb_valid = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_paddr)
      OFS_DEMOD:   next_rdata = demod_setup;
      OFS_IF_SET:  next_rdata = if_filter_setup;
      OFS_FINE:    next_rdata = fine_setup;
      OFS_RB_SEL:  next_rdata = {25'h0000000, rb_sel, 4'h0};
      OFS_PWR:     next_rdata = pwr_ctrl;
      OFS_SEQ_DIV: next_rdata = {16'h0000, seq_div};
      OFS_STATUS:  next_rdata = {26'h0000000, o_filter_trim[5],
                                 o_cal_tone_upper, o_cal_fine,
                                 o_cal_active, o_cal_done,
                                 o_adc_power_on};
      OFS_RB_DATA: next_rdata = {23'h000000, rb_valid, rb_code};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured in setup phase, stands through access
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      o_prdata <= next_rdata;
    end
  end
endmodule : ifc_filter_cal_top
`default_nettype wire

/* logic/ifc_pkg.sv */
package ifc_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_DEMOD   = 8'h00;
  localparam logic [7:0] OFS_IF_SET  = 8'h04;
  localparam logic [7:0] OFS_FINE    = 8'h08;
  localparam logic [7:0] OFS_RB_SEL  = 8'h0C;
  localparam logic [7:0] OFS_PWR     = 8'h10;
  localparam logic [7:0] OFS_SEQ_DIV = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_RB_DATA = 8'h1C;
  // if filter setup word fields
  localparam logic [3:0] IF_SET_ADDR = 4'h5;
  localparam int IF_ADDR_LSB   = 0;
  localparam int IF_COARSE_BIT = 4;
  localparam int IF_DIV_LSB    = 5;
  localparam int IF_DIV_W      = 9;
  localparam int IF_TRIM_LSB   = 14;
  localparam int IF_TRIM_W     = 6;
  localparam int IR_PH_LSB     = 20;
  localparam int IR_PH_W       = 4;
  localparam int IR_PH_DIR_BIT = 24;
  localparam int IR_GM_LSB     = 25;
  localparam int IR_GM_W       = 5;
  localparam int IR_GQ_BIT     = 30;
  localparam int IR_GDIR_BIT   = 31;
  // fine calibration setup word fields
  localparam int FINE_EN_BIT   = 4;
  localparam int DWELL_LSB     = 5;
  localparam int DWELL_W       = 11;
  localparam int SRC_STR_LSB   = 28;
  localparam int SRC_HALVE_BIT = 30;
  // demodulator setup word fields
  localparam int DOT_BIT       = 7;
  localparam int DISC_LSB      = 10;
  localparam int DISC_W        = 10;
  localparam int POST_LSB      = 20;
  localparam int POST_W        = 10;
  // power and readback
  localparam int PWR_ADC_BIT   = 8;
  localparam int RB_SEL_LSB    = 4;
  localparam int SEQ_DIV_W     = 16;
  localparam int RB_CODE_W     = 8;
  // timing: ten tone dwells per fine pass, coarse pass in if ticks
  localparam int FINE_DWELLS   = 10;
  localparam int COARSE_TICKS  = 8;
  // reset values
  localparam logic [31:0] IF_SET_RST  = 32'h0000_0005;
  localparam logic [15:0] SEQ_DIV_RST = 16'h03E8;

  typedef enum logic [2:0] {
    RB_RSSI, RB_BATT, RB_TEMP, RB_EXT, RB_FCAL
  } ifc_rb_src_t;
endpackage : ifc_pkg

/* testbench/ifc_filter_cal_props.sv */
`timescale 1ns/100ps
`default_nettype none
module ifc_filter_cal_props
  import ifc_pkg::*;
(
  // clock and reset
  input wire logic                 i_clock,
  input wire logic                 i_sys_rst,
  // apb
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_pwrite,
  input wire logic [7:0]           i_paddr,
  input wire logic [31:0]          i_pwdata,
  input wire logic                 o_pready,
  input wire logic                 o_pslverr,
  // device state
  input wire logic                 i_rx_mode,
  input wire logic [IF_TRIM_W-1:0] o_filter_trim,
  input wire logic                 o_cal_active,
  input wire logic                 o_cal_fine,
  input wire logic                 o_cal_tone_upper,
  input wire logic                 o_cal_done,
  input wire logic                 o_adc_power_on,
  input wire logic [1:0]           o_ir_test_source_strength,
  input wire logic                 o_ir_test_source_halve
);
  logic                 wr;
  logic                 tone_q;
  logic [1:0]           nseen;
  logic [IF_TRIM_W-1:0] trim_q;
  logic [2:0]           src_q;
  logic [DWELL_W-1:0]   dw_q;
  logic [SEQ_DIV_W-1:0] sd_q;
  logic [31:0]          run;
  logic [31:0]          dwell_len;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  // zero counts act as one in the sequencer
  assign dwell_len = 32'((dw_q == '0) ? 1 : dw_q)
                   * 32'((sd_q == '0) ? 1 : sd_q);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sd_q <= SEQ_DIV_RST;
    end else if (wr && i_paddr == OFS_SEQ_DIV) begin
      sd_q <= i_pwdata[SEQ_DIV_W-1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (wr && i_paddr == OFS_FINE) begin
      dw_q <= i_pwdata[DWELL_LSB +: DWELL_W];
      src_q <= i_pwdata[30:28];
    end
    if (wr && i_paddr == OFS_IF_SET) begin
      trim_q <= i_pwdata[IF_TRIM_LSB +: IF_TRIM_W];
    end
  end

  // first interval may start off a tick, so two toggles are skipped
  always_ff @(posedge i_clock) begin
    tone_q <= o_cal_tone_upper;
    run <= (tone_q != o_cal_tone_upper) ? 32'd1 : run + 32'd1;
    if (!o_cal_fine) begin
      nseen <= 2'h0;
    end else if (tone_q != o_cal_tone_upper && nseen != 2'h2) begin
      nseen <= nseen + 2'h1;
    end
  end

  property p_err_unmapped;
    (i_psel && !i_penable && (i_paddr[1:0] != 2'h0 || i_paddr > 8'h1C))
      |=> (o_pready && o_pslverr);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access not refused");

  property p_trig_start;
    (wr && i_paddr == OFS_IF_SET && i_pwdata[IF_COARSE_BIT])
      |-> ##[1:3] (o_cal_active && !o_cal_done);
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger write did not start calibration");

  property p_done_end;
    $fell(o_cal_active) |-> o_cal_done;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("calibration ended without done");

  property p_fine_alone;
    (wr && i_paddr == OFS_FINE && !o_cal_active) |=> !o_cal_active [*3];
  endproperty
  a_fine_alone: assert property (p_fine_alone)
    else $error("fine setup write started calibration");

  property p_tone_dwell;
    (o_cal_fine && nseen == 2'h2 && tone_q != o_cal_tone_upper)
      |-> run == dwell_len;
  endproperty
  a_tone_dwell: assert property (p_tone_dwell)
    else $error("tone dwell length wrong");

  property p_trim_load;
    (wr && i_paddr == OFS_IF_SET) |=> ##[0:1] (o_filter_trim == trim_q);
  endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("trim not applied");

  property p_src_ctl;
    (wr && i_paddr == OFS_FINE) |=> ##[0:1]
      ({o_ir_test_source_halve, o_ir_test_source_strength} == src_q);
  endproperty
  a_src_ctl: assert property (p_src_ctl)
    else $error("test source controls wrong");

  property p_adc_rx;
    i_rx_mode |=> o_adc_power_on;
  endproperty
  a_adc_rx: assert property (p_adc_rx)
    else $error("converter off in receive");
endmodule : ifc_filter_cal_props

bind ifc_filter_cal_top ifc_filter_cal_props u_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_rx_mode(i_rx_mode), .o_filter_trim(o_filter_trim),
  .o_cal_active(o_cal_active), .o_cal_fine(o_cal_fine),
  .o_cal_tone_upper(o_cal_tone_upper), .o_cal_done(o_cal_done),
  .o_adc_power_on(o_adc_power_on),
  .o_ir_test_source_strength(o_ir_test_source_strength),
  .o_ir_test_source_halve(o_ir_test_source_halve));
`default_nettype wire

/* testbench/ifc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ifc_host_model (
  // clock
  input  wire logic        i_clock,
  // apb master
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  input  wire logic [31:0] i_prdata
);
  int timeouts = 0;

  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clock);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_pready !== 1'b1);
    timeouts += (n > 1);
    r = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // released bus shows junk, not the old request
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : ifc_host_model
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ifc_pkg::*;
  logic        clock;
  logic        rst;
  logic        rx;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  padr;
  logic [31:0] pwd;
  logic        prdy;
  logic        perr;
  logic [31:0] prd;
  logic [7:0]  cb;
  logic [7:0]  fcal;
  logic [5:0]  trim;
  logic        act;
  logic        fine;
  logic        tone;
  logic        done;
  logic        adc;
  logic [3:0]  ph;
  logic        phd;
  logic [4:0]  gm;
  logic        gq;
  logic        gd;
  logic [1:0]  ss;
  logic        sh;
  logic [9:0]  disc;
  logic [9:0]  post;
  logic        dot;
  logic [31:0] rdat;
  logic        rerr;
  int          fails;
  int          total_checks;

  ifc_host_model host (
    .i_clock(clock), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(padr), .o_pwdata(pwd), .i_pready(prdy), .i_pslverr(perr),
    .i_prdata(prd));

  ifc_filter_cal_top i_ifc_filter_cal_top (
    .i_clock(clock), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_pready(prdy),
    .o_pslverr(perr), .o_prdata(prd), .i_rx_mode(rx),
    .i_rssi_code(cb), .i_batt_code(cb + 8'h01),
    .i_temp_code(cb + 8'h02), .i_ext_code(cb + 8'h03),
    .i_fcal_code(fcal), .o_filter_trim(trim), .o_cal_active(act),
    .o_cal_fine(fine), .o_cal_tone_upper(tone), .o_cal_done(done),
    .o_adc_power_on(adc), .o_ir_phase_correction(ph),
    .o_ir_phase_dir(phd), .o_ir_gain_correction_size(gm),
    .o_ir_gain_channel_select(gq), .o_ir_gain_dir(gd),
    .o_ir_test_source_strength(ss), .o_ir_test_source_halve(sh),
    .o_discriminator_width_word(disc),
    .o_post_detector_filter_word(post),
    .o_correlator_combine_select(dot));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string n, input int lo, input int hi,
                         input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : chk_rng

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask : rd

  task automatic run_cal(output int nc, output int nf);
    nc = 0;
    nf = 0;
    while (act !== 1'b1 && nc < 10) begin
      @(posedge clock);
      nc++;
    end
    chk("cal started", 1, act);
    nc = 0;
    while (act === 1'b1 && nc < 5000) begin
      @(posedge clock);
      nc++;
      nf += (fine === 1'b1);
    end
    chk("done at end", 1, done);
  endtask : run_cal

  task automatic t_regs;
    rd(OFS_IF_SET);
    chk("setup reset", IF_SET_RST, rdat);
    rd(OFS_SEQ_DIV);
    chk("seq div reset", 32'(SEQ_DIV_RST), rdat);
    rd(8'h20);
    chk("unmapped err", 1, rerr);
    chk("unmapped read", 0, rdat);
    wr(8'h06, 32'hFFFF_FFFF);
    chk("unaligned err", 1, rerr);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    chk("status write", 0, rerr);
    chk("idle outputs", 0, {act, done, adc, trim});
    $display("regs test done");
  endtask : t_regs

  task automatic t_fields;
    logic [31:0] w;
    w = 32'hA5CA_C025;
    wr(OFS_IF_SET, w);
    repeat (2) @(posedge clock);
    chk("ir fields", w[31:20], {gd, gq, gm, phd, ph});
    chk("trim field", w[19:14], trim);
    w = 32'h7000_0000;
    wr(OFS_FINE, w);
    repeat (2) @(posedge clock);
    chk("source", w[30:28], {sh, ss});
    // widest discriminator word a host may set
    w = (32'd660 << DISC_LSB) | (32'd75 << POST_LSB) | 32'h80;
    wr(OFS_DEMOD, w);
    repeat (2) @(posedge clock);
    chk("demod", {w[29:20], w[19:10], w[7]}, {post, disc, dot});
    $display("fields test done");
  endtask : t_fields

  task automatic t_cal;
    int nc;
    int nf;
    wr(OFS_SEQ_DIV, 32'h1);
    wr(OFS_FINE, 32'h50);
    repeat (5) @(posedge clock);
    chk("fine alone", 0, act);
    wr(OFS_FINE, 32'h40);
    wr(OFS_IF_SET, 32'h35);
    run_cal(nc, nf);
    chk("no fine", 0, nf);
    chk_rng("coarse", COARSE_TICKS - 1, COARSE_TICKS + 1, nc);
    // short dwell keeps the run small; hosts use 800 us or more
    wr(OFS_SEQ_DIV, 32'h2);
    wr(OFS_FINE, 32'h70);
    wr(OFS_IF_SET, 32'h35);
    run_cal(nc, nf);
    chk_rng("fine len", 59, 61, nf);
    chk_rng("fine follows", nf + 7, nf + 9, nc);
    chk("fine trim", 6'(fcal - 8'h80), trim);
    rd(OFS_STATUS);
    chk("status", 2'b01, rdat[2:1]);
    wr(OFS_IF_SET, 32'h000E_8025);
    repeat (2) @(posedge clock);
    chk("trim override", 6'h3A, trim);
    chk("done kept", 1, done);
    $display("calibration test done");
  endtask : t_cal

  task automatic t_readback;
    int m;
    int p;
    int s;
    logic vld;
    for (int k = 0; k < 20; k++) begin
      m = k / 10;
      p = (k / 5) % 2;
      s = k % 5;
      @(posedge clock);
      rx <= m[0];
      cb <= 8'(k * 7);
      wr(OFS_PWR, 32'(p) << PWR_ADC_BIT);
      wr(OFS_RB_SEL, 32'(s) << RB_SEL_LSB);
      rd(OFS_RB_DATA);
      vld = (s == 0) ? m[0] : (s == 4) ? 1'b1 : (m == 0 && p == 1);
      chk("readback", {vld, (s == 4) ? fcal : 8'(k * 7 + s)},
          rdat[8:0]);
      chk("adc power", (m | p), adc);
    end
    $display("readback test done");
  endtask : t_readback

  task automatic t_reset;
    wr(OFS_IF_SET, 32'h35);
    repeat (4) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("reset mid cal", 0, {act, fine, done, trim});
    rd(OFS_IF_SET);
    chk("setup after reset", IF_SET_RST, rdat);
    $display("reset test done");
  endtask : t_reset

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    finish_test;
  end

  initial begin
    rst = 1'b1;
    rx = 1'b0;
    cb = 8'h11;
    fcal = 8'h85;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_fields;
    t_cal;
    t_readback;
    t_reset;
    chk("bus waits", 0, host.timeouts);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
